//--- core/crtsf_top.sv
// Status word and flag logic of the CRT controller
`timescale 1ns/10ps
`include "crtsf_consts.svh"
module crtsf_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rd_strb,
	input wire logic wr_strb,
	input wire logic cp_sel,
	input wire crtsf_pkg::crtsf_byte_t din,
	output logic [7:0] dout,
	output logic dout_oe,
	input wire logic last_row_start,
	input wire logic buffer_swap,
	input wire logic row_buffer_full,
	input wire logic vretrace_end,
	input wire logic vretrace_in,
	input wire logic hretrace_in,
	output logic interrupt_out,
	output logic row_buffer_request,
	output logic video_blank,
	output logic vertical_retrace_out,
	output logic horizontal_retrace_out
);
	import crtsf_pkg::*;

	crtsf_core_state_t s_r;
	crtsf_core_state_t s_nxt;
	crtsf_byte_t status_word;
	logic status_read;
	logic underrun;
	logic frame_event;

	crtsf_cmd_if evt ();

	// Command decoding and parameter counting
	crtsf_decoder u_dec (
		.clk(clk),
		.arst_n(arst_n),
		.wr_strb(wr_strb),
		.cp_sel(cp_sel),
		.din(din),
		.evt(evt)
	);

	// Packs the flags into the status byte
	function automatic crtsf_byte_t crtsf_pack(input crtsf_core_state_t st);
		crtsf_byte_t w;
		w = `CRTSF_RST_BYTE;
		w[`CRTSF_STAT_ZERO] = 1'b0;
		w[`CRTSF_STAT_INT_EN] = st.int_en;
		w[`CRTSF_STAT_INT_REQ] = st.int_req;
		w[`CRTSF_STAT_UNDEF_HI] = 1'b0;
		w[`CRTSF_STAT_IMPROPER] = st.improper;
		w[`CRTSF_STAT_VIDEO_EN] = st.video_en;
		w[`CRTSF_STAT_LATE] = st.late;
		w[`CRTSF_STAT_UNDEF_LO] = 1'b0;
		return w;
	endfunction : crtsf_pack

	// Event decode
	assign status_word = crtsf_pack(s_r);
	assign status_read = rd_strb && cp_sel;
	assign frame_event = last_row_start && s_r.int_en;
	assign underrun = buffer_swap && !row_buffer_full && s_r.dma_on && !s_r.halt;

	// Next state: read clears first, commands next, events last so sets win
	always_comb begin
		s_nxt = s_r;
		s_nxt.dout_oe = 1'b0;

		// Bus read answer
		if (rd_strb) begin
			s_nxt.dout = cp_sel ? status_word : `CRTSF_RST_BYTE;
			s_nxt.dout_oe = 1'b1;
		end

		// Read side effects
		if (status_read) begin
			s_nxt.int_req = 1'b0;
			s_nxt.improper = 1'b0;
			s_nxt.late = 1'b0;
		end

		// Command actions
		case (evt.cmd)
			CRTSF_CMD_RESET: begin
				s_nxt.int_en = 1'b0;
				s_nxt.video_en = 1'b0;
				s_nxt.dma_on = 1'b0;
			end
			CRTSF_CMD_START: begin
				s_nxt.int_en = 1'b1;
				s_nxt.video_en = 1'b1;
				s_nxt.dma_on = 1'b1;
			end
			CRTSF_CMD_STOP: begin
				s_nxt.video_en = 1'b0;
			end
			CRTSF_CMD_EN_INT: begin
				s_nxt.int_en = 1'b1;
			end
			CRTSF_CMD_DIS_INT: begin
				s_nxt.int_en = 1'b0;
			end
			default: begin
				s_nxt.int_en = s_nxt.int_en;
			end
		endcase

		// Hardware sets, and halt release at retrace end
		if (frame_event) begin
			s_nxt.int_req = 1'b1;
		end
		if (evt.improper) begin
			s_nxt.improper = 1'b1;
		end
		if (vretrace_end) begin
			s_nxt.halt = 1'b0;
		end
		if (underrun) begin
			s_nxt.late = 1'b1;
			s_nxt.halt = 1'b1;
		end

		// Registered outputs
		s_nxt.irq = s_nxt.int_req;
		s_nxt.req = s_nxt.dma_on && !s_nxt.halt;
		s_nxt.blank = !(s_nxt.video_en && !s_nxt.halt);
		s_nxt.vret = vretrace_in;
		s_nxt.hret = hretrace_in;
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
			s_r.blank <= `CRTSF_RST_BLANK;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign dout = s_r.dout;
	assign dout_oe = s_r.dout_oe;
	assign interrupt_out = s_r.irq;
	assign row_buffer_request = s_r.req;
	assign video_blank = s_r.blank;
	assign vertical_retrace_out = s_r.vret;
	assign horizontal_retrace_out = s_r.hret;

	// Checks on the flag behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Status byte answer
	chk_status_read_value: assert property (
		status_read |=> dout_oe && dout == $past(status_word) && !dout[7] && !dout[4] && !dout[0])
		else $error("status byte answer wrong");

	// Enable commands
	chk_enable_commands: assert property (
		(evt.cmd == CRTSF_CMD_EN_INT || evt.cmd == CRTSF_CMD_DIS_INT)
		|=> s_r.int_en == ($past(evt.cmd) == CRTSF_CMD_EN_INT))
		else $error("enable command not applied");

	// Start sets enable and video
	chk_start_sets: assert property (
		evt.cmd == CRTSF_CMD_START |=> s_r.int_en && s_r.video_en)
		else $error("start did not set flags");

	// Reset command drops interrupt enable, video and loading; request, improper and late flags stay
	chk_reset_clears: assert property (
		evt.cmd == CRTSF_CMD_RESET |=> !s_r.int_en && !s_r.video_en && !row_buffer_request
		&& video_blank)
		else $error("reset command did not clear");

	// Request only from an enabled frame event
	chk_request_cause: assert property (
		$rose(s_r.int_req) |-> $past(last_row_start) && $past(s_r.int_en))
		else $error("interrupt request without cause");

	// Read clears request unless set again
	chk_read_clears_req: assert property (
		status_read && !frame_event |=> !s_r.int_req && !interrupt_out)
		else $error("read did not clear request");

	// Improper flag set and clear
	chk_improper_flag: assert property (
		evt.improper |=> s_r.improper)
		else $error("improper flag not set");

	chk_improper_clear: assert property (
		status_read && !evt.improper |=> !s_r.improper)
		else $error("improper flag not cleared");

	// Stop keeps interrupt enable
	chk_stop_keeps_int: assert property (
		evt.cmd == CRTSF_CMD_STOP |=> !s_r.video_en && s_r.int_en == $past(s_r.int_en))
		else $error("stop changed enable");

	// Underrun halts loading and blanks
	chk_underrun_halts: assert property (
		underrun |=> s_r.late ##1 (!row_buffer_request && video_blank))
		else $error("underrun not handled");

	// Halt holds until retrace end
	chk_halt_holds: assert property (
		s_r.halt && !vretrace_end |=> s_r.halt)
		else $error("halt released early");

	// Interrupt pin follows flag
	chk_irq_follows: assert property (
		interrupt_out == s_r.int_req)
		else $error("interrupt output lags flag");

	// Drive enable only after a read
	chk_oe_after_read: assert property (
		!rd_strb |=> !dout_oe)
		else $error("data drive without read");

	// Parameter-side read answers zero
	chk_param_read_zero: assert property (
		rd_strb && !cp_sel |=> dout == `CRTSF_RST_BYTE)
		else $error("parameter read not zero");

	// Read data holds between reads
	chk_dout_holds: assert property (
		!rd_strb |=> $stable(dout))
		else $error("read data changed without read");

	// Parameter-side read leaves request set
	chk_param_read_keeps: assert property (
		rd_strb && !cp_sel && s_r.int_req |=> s_r.int_req)
		else $error("parameter read cleared request");

	// No request while interrupts disabled
	chk_no_set_disabled: assert property (
		last_row_start && !s_r.int_en && !s_r.int_req |=> !s_r.int_req)
		else $error("request set while disabled");

	// Enabled last row raises request and pin
	chk_frame_sets_req: assert property (
		frame_event |=> s_r.int_req && interrupt_out)
		else $error("frame event did not raise request");

	// Status read clears late flag
	chk_late_clear: assert property (
		status_read && !underrun |=> !s_r.late)
		else $error("late flag not cleared");

	// Late flag holds until read
	chk_late_holds: assert property (
		s_r.late && !status_read |=> s_r.late)
		else $error("late flag dropped");

	// Halt blanks and stops loading
	chk_halt_blanks: assert property (
		s_r.halt |-> video_blank && !row_buffer_request)
		else $error("halt not blanking");

	// Retrace end releases halt
	chk_halt_release: assert property (
		s_r.halt && vretrace_end |=> !s_r.halt && row_buffer_request == s_r.dma_on)
		else $error("halt not released");

	// Stop leaves loading alone
	chk_stop_keeps_load: assert property (
		evt.cmd == CRTSF_CMD_STOP |=> s_r.dma_on == $past(s_r.dma_on))
		else $error("stop changed loading");

	// Video shown when enabled and not halted
	chk_video_shown: assert property (
		s_r.video_en && !s_r.halt |-> !video_blank)
		else $error("video blanked while enabled");

	// Blank while video is off
	chk_blank_when_off: assert property (
		!s_r.video_en |-> video_blank)
		else $error("video shown while disabled");

	// Retrace outputs keep running
	chk_retrace_copy: assert property (
		vertical_retrace_out == $past(vretrace_in)
		&& horizontal_retrace_out == $past(hretrace_in))
		else $error("retrace output not following");

	// Improper flag holds until read
	chk_improper_holds: assert property (
		s_r.improper && !status_read |=> s_r.improper)
		else $error("improper flag dropped");

	// Other commands leave enable alone
	chk_int_en_holds: assert property (
		evt.cmd inside {CRTSF_CMD_NONE, CRTSF_CMD_CURSOR, CRTSF_CMD_PRESET}
		|=> s_r.int_en == $past(s_r.int_en))
		else $error("enable changed without command");

	// Main scenarios
	cov_frame_irq: cover property (frame_event ##[1:50] status_read);
	cov_underrun: cover property (underrun ##[1:200] vretrace_end);
	cov_improper: cover property (evt.improper ##[1:20] status_read);
	cov_start_stop: cover property (evt.cmd == CRTSF_CMD_START ##[1:50] evt.cmd == CRTSF_CMD_STOP);
	cov_param_read: cover property (rd_strb && !cp_sel && s_r.int_req);
endmodule : crtsf_top

//--- core/crtsf_consts.svh
// Constants of the CRT controller status flag block
`ifndef CRTSF_CONSTS_SVH
`define CRTSF_CONSTS_SVH

// Status word bit positions
`define CRTSF_STAT_ZERO 7
`define CRTSF_STAT_INT_EN 6
`define CRTSF_STAT_INT_REQ 5
`define CRTSF_STAT_UNDEF_HI 4
`define CRTSF_STAT_IMPROPER 3
`define CRTSF_STAT_VIDEO_EN 2
`define CRTSF_STAT_LATE 1
`define CRTSF_STAT_UNDEF_LO 0

// Command opcodes, upper three bits of the command byte
`define CRTSF_OP_RESET 3'h0
`define CRTSF_OP_START 3'h1
`define CRTSF_OP_STOP 3'h2
`define CRTSF_OP_CURSOR 3'h4
`define CRTSF_OP_EN_INT 3'h5
`define CRTSF_OP_DIS_INT 3'h6
`define CRTSF_OP_PRESET 3'h7

// Parameter byte counts
`define CRTSF_NPAR_RESET 3'h4
`define CRTSF_NPAR_CURSOR 3'h2
`define CRTSF_NPAR_NONE 3'h0

// Reset values
`define CRTSF_RST_FLAG 1'b0
`define CRTSF_RST_BLANK 1'b1
`define CRTSF_RST_BYTE 8'h00

`endif

//--- core/crtsf_pkg.sv
// Types of the CRT controller status flag block
package crtsf_pkg;
	typedef logic [7:0] crtsf_byte_t;

	typedef enum logic [2:0] {
		CRTSF_CMD_NONE,
		CRTSF_CMD_RESET,
		CRTSF_CMD_START,
		CRTSF_CMD_STOP,
		CRTSF_CMD_CURSOR,
		CRTSF_CMD_EN_INT,
		CRTSF_CMD_DIS_INT,
		CRTSF_CMD_PRESET
	} crtsf_cmd_t;

	typedef struct packed {
		logic [2:0] params_left;
		crtsf_cmd_t cmd;
		logic improper;
	} crtsf_dec_state_t;

	typedef struct packed {
		logic int_en;
		logic int_req;
		logic improper;
		logic video_en;
		logic late;
		logic dma_on;
		logic halt;
		logic irq;
		logic req;
		logic blank;
		logic vret;
		logic hret;
		crtsf_byte_t dout;
		logic dout_oe;
	} crtsf_core_state_t;
endpackage : crtsf_pkg

//--- core/crtsf_cmd_if.sv
// Command events from the decoder to the flag core
`timescale 1ns/10ps
interface crtsf_cmd_if;
	import crtsf_pkg::*;
	crtsf_cmd_t cmd;
	logic improper;

	modport dec (output cmd, output improper);
	modport core (input cmd, input improper);
endinterface : crtsf_cmd_if

//--- core/crtsf_decoder.sv
// Command byte decoder and parameter byte counter
`timescale 1ns/10ps
`include "crtsf_consts.svh"
module crtsf_decoder (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wr_strb,
	input wire logic cp_sel,
	input wire crtsf_pkg::crtsf_byte_t din,
	crtsf_cmd_if.dec evt
);
	import crtsf_pkg::*;

	crtsf_dec_state_t s_r;
	crtsf_dec_state_t s_nxt;

	// Opcode to command kind
	function automatic crtsf_cmd_t crtsf_kind(input logic [2:0] op);
		case (op)
			`CRTSF_OP_RESET: crtsf_kind = CRTSF_CMD_RESET;
			`CRTSF_OP_START: crtsf_kind = CRTSF_CMD_START;
			`CRTSF_OP_STOP: crtsf_kind = CRTSF_CMD_STOP;
			`CRTSF_OP_CURSOR: crtsf_kind = CRTSF_CMD_CURSOR;
			`CRTSF_OP_EN_INT: crtsf_kind = CRTSF_CMD_EN_INT;
			`CRTSF_OP_DIS_INT: crtsf_kind = CRTSF_CMD_DIS_INT;
			`CRTSF_OP_PRESET: crtsf_kind = CRTSF_CMD_PRESET;
			default: crtsf_kind = CRTSF_CMD_NONE;
		endcase
	endfunction : crtsf_kind

	// Parameter bytes each opcode expects
	function automatic logic [2:0] crtsf_npar(input logic [2:0] op);
		case (op)
			`CRTSF_OP_RESET: crtsf_npar = `CRTSF_NPAR_RESET;
			`CRTSF_OP_CURSOR: crtsf_npar = `CRTSF_NPAR_CURSOR;
			default: crtsf_npar = `CRTSF_NPAR_NONE;
		endcase
	endfunction : crtsf_npar

	// Command and parameter writes, count check
	always_comb begin
		s_nxt = s_r;
		s_nxt.cmd = CRTSF_CMD_NONE;
		s_nxt.improper = 1'b0;
		if (wr_strb && cp_sel) begin
			if (s_r.params_left != `CRTSF_NPAR_NONE) begin
				s_nxt.improper = 1'b1;
			end
			s_nxt.cmd = crtsf_kind(din[7:5]);
			s_nxt.params_left = crtsf_npar(din[7:5]);
		end else if (wr_strb) begin
			if (s_r.params_left == `CRTSF_NPAR_NONE) begin
				s_nxt.improper = 1'b1;
			end else begin
				s_nxt.params_left = s_r.params_left - 3'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign evt.cmd = s_r.cmd;
	assign evt.improper = s_r.improper;
endmodule : crtsf_decoder

//--- tb/crtsf_host.sv
// Host processor model on the controller's parallel bus
`timescale 1ns/10ps
module crtsf_host (
	input wire logic clk,
	output logic rd_strb,
	output logic wr_strb,
	output logic cp_sel,
	output crtsf_pkg::crtsf_byte_t din,
	input wire logic [7:0] dout,
	input wire logic dout_oe
);
	import crtsf_pkg::*;
	// Idle bus at time zero
	initial begin
		rd_strb = 1'b0;
		wr_strb = 1'b0;
		cp_sel = 1'b1;
		din = 8'h00;
	end
	// One byte write; released data inverted so stale bytes never look valid
	task automatic wr(input logic cp, input crtsf_byte_t b);
		@(posedge clk);
		wr_strb <= 1'b1;
		cp_sel <= cp;
		din <= b;
		@(posedge clk);
		wr_strb <= 1'b0;
		din <= ~b;
	endtask : wr
	// One read; data taken only while the drive enable is high
	task automatic rd(input logic cp, output crtsf_byte_t b);
		@(posedge clk);
		rd_strb <= 1'b1;
		cp_sel <= cp;
		@(posedge clk);
		rd_strb <= 1'b0;
		// Answer taken at the edge where the drive enable is still seen high
		@(posedge clk);
		b = (dout_oe === 1'b1) ? dout : 8'hFF;
	endtask : rd
endmodule : crtsf_host

//--- tb/test_crtsf_top.sv
// Self-checking bench for the CRT controller status flags
`timescale 1ns/10ps
module test_crtsf_top;
	import crtsf_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic rd_strb, wr_strb, cp_sel, dout_oe, irq, req, blank, vout, hout;
	crtsf_byte_t din;
	logic [7:0] dout;
	logic lrs = 1'b0, swp = 1'b0, full = 1'b1, vend = 1'b0, vin = 1'b0, hin = 1'b0;
	int err_total = 0;
	int check_count = 0;
	// Character clock
	always #25 clk = ~clk;
	crtsf_host host (.clk(clk), .rd_strb(rd_strb), .wr_strb(wr_strb), .cp_sel(cp_sel),
		.din(din), .dout(dout), .dout_oe(dout_oe));
	crtsf_top dut (.clk(clk), .arst_n(arst_n), .rd_strb(rd_strb), .wr_strb(wr_strb),
		.cp_sel(cp_sel), .din(din), .dout(dout), .dout_oe(dout_oe), .last_row_start(lrs),
		.buffer_swap(swp), .row_buffer_full(full), .vretrace_end(vend), .vretrace_in(vin),
		.hretrace_in(hin), .interrupt_out(irq), .row_buffer_request(req),
		.video_blank(blank), .vertical_retrace_out(vout), .horizontal_retrace_out(hout));
	// Compare helpers
	task automatic chk_byte(input crtsf_byte_t got, input crtsf_byte_t exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t status got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_pin(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk_pin
	task automatic stat(input crtsf_byte_t exp);
		crtsf_byte_t b;
		host.rd(1'b1, b);
		chk_byte(b, exp);
	endtask : stat
	task automatic pins(input logic r, input logic bl);
		chk_pin(req, r, "request");
		chk_pin(blank, bl, "blank");
	endtask : pins
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// One-cycle display event: 0 last row, 1 swap with empty buffer, 2 retrace end
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: lrs <= 1'b1;
			1: begin
				swp <= 1'b1;
				full <= 1'b0;
			end
			default: vend <= 1'b1;
		endcase
		@(posedge clk);
		lrs <= 1'b0;
		swp <= 1'b0;
		vend <= 1'b0;
		full <= 1'b1;
	endtask : pulse
	// Scenarios
	task automatic t_start();
		stat(8'h00);
		pins(1'b0, 1'b1);
		host.wr(1'b1, 8'h20);
		wt(2);
		pins(1'b1, 1'b0);
		stat(8'h44);
		$display("test start done");
	endtask : t_start
	task automatic t_irq();
		crtsf_byte_t b;
		pulse(0);
		wt(2);
		chk_pin(irq, 1'b1, "interrupt");
		host.rd(1'b0, b);
		chk_byte(b, 8'h00);
		stat(8'h64);
		wt(1);
		chk_pin(irq, 1'b0, "interrupt");
		stat(8'h44);
		host.wr(1'b1, 8'hC0);
		wt(2);
		stat(8'h04);
		pulse(0);
		wt(2);
		chk_pin(irq, 1'b0, "interrupt");
		stat(8'h04);
		host.wr(1'b1, 8'hA0);
		wt(2);
		stat(8'h44);
		$display("test interrupt done");
	endtask : t_irq
	task automatic t_improper();
		host.wr(1'b0, 8'h55);
		wt(2);
		stat(8'h4C);
		stat(8'h44);
		host.wr(1'b1, 8'h80);
		host.wr(1'b0, 8'h01);
		host.wr(1'b1, 8'hA0);
		wt(2);
		stat(8'h4C);
		stat(8'h44);
		$display("test improper done");
	endtask : t_improper
	task automatic t_underrun();
		pulse(1);
		wt(1);
		pins(1'b0, 1'b1);
		stat(8'h46);
		pins(1'b0, 1'b1);
		pulse(2);
		wt(1);
		pins(1'b1, 1'b0);
		$display("test underrun done");
	endtask : t_underrun
	task automatic t_stop_reset();
		host.wr(1'b1, 8'h40);
		host.wr(1'b1, 8'hE0);
		wt(2);
		pins(1'b1, 1'b1);
		stat(8'h40);
		@(posedge clk);
		vin <= 1'b1;
		hin <= 1'b1;
		host.wr(1'b1, 8'h00);
		repeat (4) host.wr(1'b0, 8'h3C);
		wt(2);
		pins(1'b0, 1'b1);
		stat(8'h00);
		chk_pin(vout, 1'b1, "vretrace");
		chk_pin(hout, 1'b1, "hretrace");
		$display("test stop and reset done");
	endtask : t_stop_reset
	// Verdict
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		wt(1);
		t_start();
		t_irq();
		t_improper();
		t_underrun();
		t_stop_reset();
		test_done();
	end
	// Watchdog, far beyond the roughly 110 cycles the tests need
	initial begin
		#100000;
		err_total++;
		$display("ERROR %0t watchdog expired", $time);
		test_done();
	end
endmodule : test_crtsf_top
